// File: rtl/cirq_regs.svh
// register offsets, field positions, reset values for the card irq block
`ifndef CIRQ_REGS_SVH
`define CIRQ_REGS_SVH
`define CIRQ_GLOBAL_OFS    8'h00
`define CIRQ_WINEN_OFS     8'h01
`define CIRQ_CSC_OFS       8'h02
`define CIRQ_GLOBAL_RST    4'h0
`define CIRQ_WINEN_RST     8'h00
`define CIRQ_CSC_RST       4'h0
`define CIRQ_TRIG_BIT      3
`define CIRQ_ACK_BIT       2
`define CIRQ_LDRV_BIT      1
`define CIRQ_RSV_BIT       0
`define CIRQ_IO_WIN1_BIT   7
`define CIRQ_IO_WIN0_BIT   6
`define CIRQ_MEM_WIN_MSB   4
`define CIRQ_NUM_WIN       7
`define CIRQ_NUM_MEM_WIN   5
`endif

// File: rtl/cirq_pkg.sv
// types shared by the card irq and window enable block
package cirq_pkg;
    typedef logic [23:0] cirq_addr_type;
    typedef logic [7:0]  cirq_byte_type;
    typedef logic [6:0]  cirq_win_type;
    typedef logic [6:0][23:0] cirq_bound_type;
    typedef logic [3:0]  cirq_csc_type;
    typedef enum logic [0:0] {
        CIRQ_TRIG_EDGE  = 1'b0,
        CIRQ_TRIG_LEVEL = 1'b1
    } cirq_trig_type;
endpackage

// File: rtl/cirq_win_if.sv
// host access and window match signals between control and decoder
`timescale 1ns/10ps
interface cirq_win_if;
    import cirq_pkg::*;
    logic           valid;
    logic           is_io;
    cirq_addr_type  addr;
    cirq_win_type   enable;
    cirq_bound_type lo;
    cirq_bound_type hi;
    cirq_win_type   hit;
    logic           card_en;
    modport ctrl (output valid, is_io, addr, enable, lo, hi,
                  input hit, card_en);
    modport dec  (input valid, is_io, addr, enable, lo, hi,
                  output hit, card_en);
endinterface

// File: rtl/cirq_win_dec.sv
// window range decoder with registered card enable
`timescale 1ns/10ps
`include "cirq_regs.svh"
module cirq_win_dec
    import cirq_pkg::*;
(
    input  wire logic sys_clk,  // system clock
    input  wire logic nrst,     // async reset, active low
    input  wire logic clk_en,   // freezes state when low
    cirq_win_if.dec   win       // access and match signals
);
    cirq_win_type hit_d;
    cirq_win_type hit_q;
    logic         card_en_q;

    // windows 0..4 are memory, 5..6 are io; io compares only 16 bits
    genvar i;
    generate
        for (i = 0; i < `CIRQ_NUM_WIN; i++) begin : g_win
            localparam bit IS_IO = (i >= `CIRQ_NUM_MEM_WIN);
            wire [23:0] a  = IS_IO ? {8'h00, win.addr[15:0]} : win.addr;
            wire [23:0] lo = IS_IO ? {8'h00, win.lo[i][15:0]} : win.lo[i];
            wire [23:0] hi = IS_IO ? {8'h00, win.hi[i][15:0]} : win.hi[i];
            // equal bounds give a one byte window
            wire in_rng = (a >= lo) && (a <= hi);
            // disabled window inhibits card enable
            assign hit_d[i] = win.valid && (win.is_io == IS_IO)
                              && in_rng && win.enable[i];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hit_q     <= 7'h00;
            card_en_q <= 1'b0;
        end else if (clk_en) begin
            hit_q     <= hit_d;
            card_en_q <= |hit_d;
        end
    end

    assign win.hit     = hit_q;
    assign win.card_en = card_en_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_card_en_cause: assert property (
        $past(clk_en) && card_en_q |->
            $past(win.valid) && (($past(win.enable) & hit_q) != 7'h00))
        else $error("card enable without enabled matching window");

    a_one_byte_win: assert property (
        clk_en && win.valid && !win.is_io && win.enable[0]
        && win.lo[0] == win.hi[0] && win.addr == win.lo[0]
        |=> hit_q[0] && card_en_q)
        else $error("single byte memory window did not match");

    a_io_win_off: assert property (
        clk_en && !win.enable[5] && !win.enable[6] && win.is_io
        |=> !card_en_q)
        else $error("io access passed with io windows off");
endmodule

// File: rtl/cirq_ctrl.sv
// global interrupt control and window enable registers of the card port
//
// Operation
// - one global control register for both sockets, cleared on reset.
// - global control bits 7-4 read zero and ignore writes.
// - trigger select bit 3: one level, zero edge card interrupts.
// - ack select one: writing one clears that status change flag.
// - ack select zero: any status change read clears all flags.
// - level drive one: line floats, pulled low while interrupt active.
// - level drive zero: enabled line low, high when active, else float.
// - global control bit 0 is a stored read/write spare bit.
// - window enable register clears on reset; all windows disabled.
// - io window enable bit zero inhibits card enable for that window.
// - memory window enable bit zero inhibits card enable there.
// - window enable bit 5 is a stored spare bit, resets zero.
// - equal start and stop bounds form a valid one byte window.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "cirq_regs.svh"
module cirq_ctrl
    import cirq_pkg::*;
(
    input  wire logic           sys_clk,        // system clock
    input  wire logic           nrst,           // async reset, active low
    input  wire logic           clk_en,         // freezes state when low
    input  wire logic [7:0]     reg_addr,       // register address
    input  wire logic [7:0]     reg_wdata,      // register write data
    input  wire logic           reg_wr,         // write strobe
    input  wire logic           reg_rd,         // read strobe
    output logic      [7:0]     reg_rdata,      // read data, next cycle
    input  wire logic           card_ireq,      // card interrupt request
    input  wire cirq_csc_type   status_event,   // card status change events
    input  wire logic           irq_enable,     // host line steered on
    output logic                host_irq_out,   // host interrupt line out
    output logic                host_irq_oe_n,  // line drive enable, low
    input  wire logic           acc_valid,      // host access to the card
    input  wire logic           acc_io,         // access is io, else memory
    input  wire cirq_addr_type  acc_addr,       // access address
    input  wire cirq_bound_type win_start,      // window start bounds
    input  wire cirq_bound_type win_stop,       // window stop bounds
    output logic                card_enable,    // card enable strobe
    output cirq_win_type        window_hit      // windows that matched
);
    logic [3:0]    glob_q;
    logic [3:0]    glob_d;
    cirq_byte_type wen_q;
    cirq_csc_type  csc_q;
    cirq_csc_type  csc_d;
    cirq_byte_type rdata_q;
    cirq_byte_type rdata_d;
    logic          card_prev_q;
    logic          irq_out_q;
    logic          irq_out_d;
    logic          irq_oe_n_q;
    logic          irq_oe_n_d;

    cirq_win_if win ();

    // register decode
    wire wr_glob = reg_wr && (reg_addr == `CIRQ_GLOBAL_OFS);
    wire wr_wen  = reg_wr && (reg_addr == `CIRQ_WINEN_OFS);
    wire wr_csc  = reg_wr && (reg_addr == `CIRQ_CSC_OFS);
    wire rd_glob = reg_rd && (reg_addr == `CIRQ_GLOBAL_OFS);
    wire rd_wen  = reg_rd && (reg_addr == `CIRQ_WINEN_OFS);
    wire rd_csc  = reg_rd && (reg_addr == `CIRQ_CSC_OFS);

    wire trig_level = (glob_q[`CIRQ_TRIG_BIT] == CIRQ_TRIG_LEVEL);
    wire ack_write  = glob_q[`CIRQ_ACK_BIT];
    wire level_drv  = glob_q[`CIRQ_LDRV_BIT];

    // only the low nibble is stored; upper bits never hold state
    assign glob_d = wr_glob ? reg_wdata[3:0] : glob_q;

    // flag clear depends on ack select sampled at the access
    wire cirq_csc_type csc_wclr = (ack_write && wr_csc) ?
                                  reg_wdata[3:0] : 4'h0;
    // read side effect clears everything in read-ack mode
    wire cirq_csc_type csc_rclr = (!ack_write && rd_csc) ? 4'hF : 4'h0;
    // a new event in the clearing cycle survives
    assign csc_d = (csc_q & ~(csc_wclr | csc_rclr)) | status_event;

    // read data; unmapped addresses return zero
    assign rdata_d = rd_glob ? {4'h0, glob_q} :
                     rd_wen  ? wen_q :
                     rd_csc  ? {4'h0, csc_q} :
                     8'h00;

    // edge mode passes one pulse per rising request
    wire card_act = trig_level ? card_ireq : (card_ireq && !card_prev_q);
    wire line_act = card_act || (csc_q != 4'h0);

    // open-drain style vs totem-pole style line drive
    assign irq_out_d  = level_drv ? 1'b0 : line_act;
    assign irq_oe_n_d = level_drv ? !line_act : !irq_enable;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            glob_q <= `CIRQ_GLOBAL_RST;
            wen_q  <= `CIRQ_WINEN_RST;
        end else if (clk_en) begin
            glob_q <= glob_d;
            if (wr_wen) begin
                wen_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            csc_q       <= `CIRQ_CSC_RST;
            rdata_q     <= 8'h00;
            card_prev_q <= 1'b0;
        end else if (clk_en) begin
            csc_q       <= csc_d;
            rdata_q     <= rdata_d;
            card_prev_q <= card_ireq;
        end
    end

    // line floats in reset; after it, the reset level drive zero style drives it whenever irq_enable is high
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_out_q  <= 1'b0;
            irq_oe_n_q <= 1'b1;
        end else if (clk_en) begin
            irq_out_q  <= irq_out_d;
            irq_oe_n_q <= irq_oe_n_d;
        end
    end

    // window enables map to decoder slots: mem 0..4, then io 0..1
    assign win.valid  = acc_valid;
    assign win.is_io  = acc_io;
    assign win.addr   = acc_addr;
    assign win.enable = {wen_q[`CIRQ_IO_WIN1_BIT], wen_q[`CIRQ_IO_WIN0_BIT],
                         wen_q[`CIRQ_MEM_WIN_MSB:0]};
    // bounds are trusted as programmed before enabling
    assign win.lo     = win_start;
    assign win.hi     = win_stop;

    cirq_win_dec u_dec (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .win     (win.dec)
    );

    assign reg_rdata     = rdata_q;
    assign host_irq_out  = irq_out_q;
    assign host_irq_oe_n = irq_oe_n_q;
    assign card_enable   = win.card_en;
    assign window_hit    = win.hit;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_glob_write;
        clk_en && wr_glob;
    endsequence

    sequence s_glob_read;
        clk_en && rd_glob;
    endsequence

    sequence s_frozen;
        !clk_en;
    endsequence

    sequence s_bus_idle;
        clk_en && !reg_rd;
    endsequence

    sequence s_other_read;
        clk_en && reg_rd && !rd_glob && !rd_wen && !rd_csc;
    endsequence

    sequence s_other_write;
        clk_en && reg_wr && !wr_glob && !wr_wen && !wr_csc;
    endsequence

    sequence s_wen_read;
        clk_en && rd_wen;
    endsequence

    sequence s_csc_read;
        clk_en && rd_csc;
    endsequence

    a_reset_clears: assert property (
        $past(!nrst) |-> glob_q == 4'h0 && wen_q == 8'h00 && irq_oe_n_q)
        else $error("registers not cleared after reset");

    a_upper_read_zero: assert property (
        s_glob_read |=> reg_rdata[7:4] == 4'h0)
        else $error("global control upper bits not zero");

    a_spare_bit_kept: assert property (
        s_glob_write ##1 s_glob_read |=>
            reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
        else $error("global control write not read back");

    a_edge_one_pulse: assert property (
        clk_en && !trig_level && !level_drv && card_prev_q && card_ireq
        && csc_q == 4'h0 |=> !host_irq_out)
        else $error("edge mode repeated a held request");

    a_write_ack: assert property (
        clk_en && ack_write && wr_csc && status_event == 4'h0 |=>
            csc_q == ($past(csc_q) & ~$past(reg_wdata[3:0])))
        else $error("write acknowledge cleared wrong flags");

    a_read_ack: assert property (
        clk_en && !ack_write && rd_csc && status_event == 4'h0
        |=> csc_q == 4'h0)
        else $error("read acknowledge left flags set");

    a_event_wins: assert property (
        clk_en && status_event != 4'h0 |=>
            (csc_q & $past(status_event)) == $past(status_event))
        else $error("status change event lost");

    a_level_drive: assert property (
        clk_en && level_drv |=>
            !host_irq_out && host_irq_oe_n == !$past(line_act))
        else $error("level drive mode pin state wrong");

    a_edge_drive: assert property (
        clk_en && !level_drv |=>
            host_irq_oe_n == !$past(irq_enable)
            && host_irq_out == $past(line_act))
        else $error("edge drive mode pin state wrong");

    a_winen_store: assert property (
        clk_en && wr_wen |=> wen_q == $past(reg_wdata))
        else $error("window enable write not stored");

    a_mem_win_off: assert property (
        clk_en && !acc_io && wen_q[`CIRQ_MEM_WIN_MSB:0] == 5'h00
        |=> !card_enable)
        else $error("memory access passed with windows off");

    // a low enable must hold every flop, pins included
    a_freeze_state: assert property (
        s_frozen |=> $stable(glob_q) && $stable(wen_q) && $stable(csc_q))
        else $error("state moved while clock enable low");

    a_freeze_pins: assert property (
        s_frozen |=> $stable(reg_rdata) && $stable(host_irq_out)
            && $stable(host_irq_oe_n) && $stable(card_enable)
            && $stable(window_hit))
        else $error("outputs moved while clock enable low");

    // idle cycles reload zero so stale data never lingers
    a_idle_rdata: assert property (
        s_bus_idle |=> reg_rdata == 8'h00)
        else $error("read data not zero after idle cycle");

    a_unmapped_read: assert property (
        s_other_read |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");

    a_unmapped_write: assert property (
        s_other_write |=> $stable(glob_q) && $stable(wen_q))
        else $error("unmapped write changed a register");

    a_winen_read: assert property (
        s_wen_read |=> reg_rdata == $past(wen_q))
        else $error("window enable read back wrong");

    a_glob_read_value: assert property (
        s_glob_read |=> reg_rdata[3:0] == $past(glob_q))
        else $error("global control read back wrong");

    // the read reports the flags as they stood before the clear
    a_csc_read_value: assert property (
        s_csc_read |=> reg_rdata == {4'h0, $past(csc_q)})
        else $error("status change read lost flags");

    a_csc_ack_hold: assert property (
        clk_en && ack_write && !wr_csc && status_event == 4'h0
        |=> csc_q == $past(csc_q))
        else $error("flags cleared without write acknowledge");

    a_level_trigger: assert property (
        clk_en && trig_level && level_drv && card_ireq
        |=> !host_irq_oe_n && !host_irq_out)
        else $error("level request did not pull the line");

    a_edge_rise: assert property (
        clk_en && !trig_level && !level_drv && card_ireq && !card_prev_q
        |=> host_irq_out)
        else $error("edge request did not raise the line");

    a_line_float: assert property (
        clk_en && !level_drv && !irq_enable |=> host_irq_oe_n)
        else $error("disabled line still driven");

    a_glob_hold: assert property (
        clk_en && !wr_glob |=> $stable(glob_q))
        else $error("global control changed without write");

    a_wen_hold: assert property (
        clk_en && !wr_wen |=> $stable(wen_q))
        else $error("window enable changed without write");
endmodule

// File: verification/cirq_card_model.sv
// behavioural 16-bit card facing the bridge
`timescale 1ns/10ps
module cirq_card_model (
    input  wire logic       sys_clk,      // system clock
    input  wire logic       nrst,         // async reset, active low
    input  wire logic       irq_req,      // bench asks for an interrupt
    input  wire logic [3:0] evt_req,      // bench asks for status events
    input  wire logic       card_enable,  // enable strobe from bridge
    output logic            card_ireq,    // interrupt request to bridge
    output logic [3:0]      status_event, // status change pulses
    output int              n_sel         // enable strobes seen
);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            card_ireq    <= 1'b0;
            status_event <= 4'h0;
            n_sel        <= 0;
        end else begin
            // one cycle late on purpose, like a slow card
            card_ireq    <= irq_req;
            status_event <= evt_req;
            n_sel        <= n_sel + int'(card_enable);
        end
    end
endmodule

// File: verification/test_cirq_ctrl.sv
// self-checking bench for the card irq and window enable block
`timescale 1ns/10ps
module test_cirq_ctrl;
    import cirq_pkg::*;
    logic           sys_clk, nrst, reg_wr, reg_rd, irq_enable, irq_req;
    logic           acc_valid, acc_io, card_ireq, card_enable, clk_en;
    logic           host_irq_out, host_irq_oe_n;
    logic [7:0]     reg_addr, reg_wdata, reg_rdata;
    cirq_csc_type   evt_req, status_event;
    cirq_addr_type  acc_addr;
    cirq_bound_type win_start, win_stop;
    cirq_win_type   window_hit;
    int             mismatches, n_checks, n_sel, cnt;

    cirq_ctrl cirq_ctrl_i (.sys_clk, .nrst, .clk_en, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .card_ireq,
        .status_event, .irq_enable, .host_irq_out, .host_irq_oe_n,
        .acc_valid, .acc_io, .acc_addr, .win_start, .win_stop,
        .card_enable, .window_hit);
    cirq_card_model cirq_card_model_i (.sys_clk, .nrst, .irq_req,
        .evt_req, .card_enable, .card_ireq, .status_event, .n_sel);

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk8(reg_rdata, exp);
    endtask
    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] exp);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk8(reg_rdata, exp);
    endtask
    task automatic acc(input logic io, input logic [23:0] a,
                       input logic [6:0] hit);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_io <= io;
        acc_addr <= a;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        @(negedge sys_clk);
        chk1(card_enable, |hit);
        chk8({1'b0, window_hit}, {1'b0, hit});
    endtask
    // level inputs need card delay plus one register to show
    task automatic irq(input logic v, input logic oe_n, input logic o);
        @(posedge sys_clk);
        irq_req <= v;
        repeat (3) @(negedge sys_clk);
        chk1(host_irq_oe_n, oe_n);
        chk1(host_irq_out, o);
    endtask
    task automatic ev(input logic [3:0] e);
        @(posedge sys_clk);
        evt_req <= e;
        @(posedge sys_clk);
        evt_req <= 4'h0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #200us;
        mismatches++;
        tally_and_finish;
    end

    initial begin
        {reg_wr, reg_rd, acc_valid, acc_io, irq_req} = 5'h0;
        {reg_addr, reg_wdata, evt_req, acc_addr} = 44'h0;
        {irq_enable, mismatches, n_checks, nrst} = 66'h0;
        clk_en = 1'b1;
        // bounds settle before any window is enabled
        for (int i = 0; i < 7; i++) begin
            win_start[i] = {8'h0, i[7:0], 8'h10};
            win_stop[i] = win_start[i] + ((i == 0) ? 24'h0 : 24'hf);
        end
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd8(8'h00, 8'h00);
        rd8(8'h01, 8'h00);
        wr(8'h00, 8'hff);
        rd8(8'h00, 8'h0f);
        wr(8'h01, 8'h20);
        rd8(8'h01, 8'h20);
        wr(8'h05, 8'h00);
        rd8(8'h05, 8'h00);
        rd8(8'h00, 8'h0f);
        // a strobe while frozen is lost
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h00, 8'h00);
        clk_en <= 1'b1;
        rd8(8'h00, 8'h0f);
        wr_rd(8'h00, 8'hf1, 8'h01);
        for (int i = 0; i < 7; i++) begin
            wr(8'h01, 8'h00);
            acc(i > 4, win_start[i], 7'h00);
            wr(8'h01, 8'h01 << ((i < 5) ? i : i + 1));
            acc(i > 4, win_stop[i], 7'h01 << i);
            acc(i > 4, win_stop[i] + 24'h1, 7'h00);
            acc(i < 5, win_start[i], 7'h00);
        end
        chk8(8'(n_sel), 8'h07);
        @(posedge sys_clk);
        irq_enable <= 1'b1;
        wr(8'h00, 8'h0a);
        irq(1'b1, 1'b0, 1'b0);
        irq(1'b0, 1'b1, 1'b0);
        wr(8'h00, 8'h08);
        irq(1'b1, 1'b0, 1'b1);
        irq(1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        irq_enable <= 1'b0;
        irq(1'b0, 1'b1, 1'b0);
        @(posedge sys_clk);
        irq_enable <= 1'b1;
        wr(8'h00, 8'h00);
        @(posedge sys_clk);
        irq_req <= 1'b1;
        cnt = 0;
        // a held request must give a single pulse in edge mode
        repeat (8) begin
            @(negedge sys_clk);
            cnt += int'(host_irq_out === 1'b1);
        end
        chk8(8'(cnt), 8'h01);
        irq(1'b0, 1'b0, 1'b0);
        ev(4'h2);
        rd8(8'h02, 8'h02);
        rd8(8'h02, 8'h00);
        wr(8'h00, 8'h04);
        ev(4'h5);
        rd8(8'h02, 8'h05);
        wr(8'h02, 8'h01);
        rd8(8'h02, 8'h04);
        // mid-run reset while the line is driven high
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(negedge sys_clk);
        chk1(host_irq_oe_n, 1'b1);
        chk1(host_irq_out, 1'b0);
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd8(8'h00, 8'h00);
        rd8(8'h01, 8'h00);
        tally_and_finish;
    end
endmodule
